// file: reset_cause_pkg.sv
// shared constants and types of the reset cause recorder
// assumes a 13-bit program counter and a 32-bit avalon-mm register port
package reset_cause_pkg;
   // program counter width and vectors
   localparam int PC_W = 13;
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] INT_VECTOR = 13'h0004;
   localparam logic [12:0] PC_STEP = 13'h0001;
   // register byte offsets
   localparam int ADDR_W = 4;
   localparam logic [3:0] FLAGS_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] CONFIG_OFS = 4'h8;
   // field positions of the reset_cause_flags register
   localparam int OVERFLOW_POS = 7;
   localparam int UNDERFLOW_POS = 6;
   localparam int PIN_POS = 3;
   localparam int INSTR_POS = 2;
   localparam int POWERON_POS = 1;
   localparam int BROWNOUT_POS = 0;
   // field positions of the status and config registers
   localparam int TIMEOUT_POS = 4;
   localparam int POWERDOWN_POS = 3;
   localparam int CONFIG_STACK_POS = 0;
   // reset values and masks
   localparam logic [7:0] FLAGS_RESET = 8'h0C;
   localparam logic [7:0] FLAGS_MASK = 8'hCF;
   localparam logic [4:0] STATUS_RESET = 5'h18;
   localparam logic [4:0] STATUS_SW_MASK = 5'h07;
   localparam logic CONFIG_RESET = 1'b1;
   // no-cause value, then reset and wake causes, highest priority first
   typedef enum logic [3:0] {
      CAUSE_NONE, CAUSE_POWERON, CAUSE_BROWNOUT, CAUSE_PIN, CAUSE_WDT_RESET,
      CAUSE_INSTR, CAUSE_OVERFLOW, CAUSE_UNDERFLOW, CAUSE_WDT_WAKE,
      CAUSE_INT_WAKE
   } cause_t;
   // interrupt vectoring after wake-up
   typedef enum logic [0:0] {ST_IDLE, ST_WAIT_INSTR} vec_state_t;
endpackage

// file: reset_event_if.sv
// bundle of reset and wake events plus the decoded cause
// assumes all events are one-cycle pulses on the core clock
`timescale 1ns/100ps
interface reset_event_if;
   import reset_cause_pkg::*;
   logic powerOn; // power-on reset pulse
   logic brownout; // brown-out reset pulse
   logic pinReset; // filtered external_reset_pin reset pulse
   logic wdtReset; // watchdog reset pulse
   logic wdtWake; // watchdog wake from sleep pulse
   logic intWake; // interrupt wake from sleep pulse
   logic resetInstr; // reset instruction executed pulse
   logic stackOverflow; // stack overflow pulse
   logic stackUnderflow; // stack underflow pulse
   logic stackResetEnable; // stack_reset_enable config bit
   cause_t cause; // winning cause of this cycle
   modport source (output powerOn, brownout, pinReset, wdtReset, wdtWake,
      intWake, resetInstr, stackOverflow, stackUnderflow, stackResetEnable,
      input cause);
   modport decoder (input powerOn, brownout, pinReset, wdtReset, wdtWake,
      intWake, resetInstr, stackOverflow, stackUnderflow, stackResetEnable,
      output cause);
endinterface

// file: cause_decoder.sv
// priority decoder that picks one reset or wake cause per cycle
// assumes event pulses from logic on the same clock
`timescale 1ns/100ps
module cause_decoder (
   reset_event_if.decoder ev
);
   import reset_cause_pkg::*;

   // fixed priority: supply events first, then resets, then wake-ups
   always_comb begin
      if (ev.powerOn) begin
         ev.cause = CAUSE_POWERON;
      end else if (ev.brownout) begin
         ev.cause = CAUSE_BROWNOUT;
      end else if (ev.pinReset) begin
         ev.cause = CAUSE_PIN;
      end else if (ev.wdtReset) begin
         ev.cause = CAUSE_WDT_RESET;
      end else if (ev.resetInstr) begin
         ev.cause = CAUSE_INSTR;
      end else if (ev.stackOverflow && ev.stackResetEnable) begin
         ev.cause = CAUSE_OVERFLOW;
      end else if (ev.stackUnderflow && ev.stackResetEnable) begin
         ev.cause = CAUSE_UNDERFLOW;
      end else if (ev.wdtWake) begin
         ev.cause = CAUSE_WDT_WAKE;
      end else if (ev.intWake) begin
         ev.cause = CAUSE_INT_WAKE;
      end else begin
         ev.cause = CAUSE_NONE;
      end
   end
endmodule

// file: reset_cause_recorder.sv
// reset cause recorder: flags, status bits and program counter action
// assumes event inputs are one-cycle pulses from logic on clk_sys
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module reset_cause_recorder (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [reset_cause_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic powerOnEvent,
   input wire logic brownoutEvent,
   input wire logic pinResetEvent,
   input wire logic watchdogResetEvent,
   input wire logic watchdogWakeEvent,
   input wire logic interruptWakeEvent,
   input wire logic resetInstrEvent,
   input wire logic stackOverflowEvent,
   input wire logic stackUnderflowEvent,
   input wire logic inSleep,
   input wire logic globalIntEnable,
   input wire logic instrDone,
   input wire logic [reset_cause_pkg::PC_W-1:0] currentPc,
   output logic pcLoad,
   output logic [reset_cause_pkg::PC_W-1:0] pcValue,
   output logic returnPush,
   output logic [reset_cause_pkg::PC_W-1:0] returnAddr,
   output logic [4:0] statusBits
);
   import reset_cause_pkg::*;

   // register state
   logic [7:0] flags_q, flags_d; // reset_cause_flags
   logic [4:0] status_q, status_d; // time-out, power-down, arithmetic bits
   logic stackEnable_q, stackEnable_d; // stack_reset_enable
   // bus state
   logic waitReq_q, waitReq_d;
   logic [31:0] rdData_q, rdData_d;
   // program counter side
   logic pcLoad_q, pcLoad_d;
   logic [PC_W-1:0] pcValue_q, pcValue_d;
   logic push_q, push_d;
   logic [PC_W-1:0] pushAddr_q, pushAddr_d;
   logic [PC_W-1:0] retPc_q, retPc_d; // saved resume address
   vec_state_t state_q, state_d;
   // decoded access strobes
   logic wrTaken;
   logic wrFlags, wrStatus, wrConfig;
   cause_t causeSel;

   // event bundle and priority decoder
   reset_event_if ev ();
   assign ev.powerOn = powerOnEvent;
   assign ev.brownout = brownoutEvent;
   assign ev.pinReset = pinResetEvent;
   assign ev.wdtReset = watchdogResetEvent;
   assign ev.wdtWake = watchdogWakeEvent;
   assign ev.intWake = interruptWakeEvent;
   assign ev.resetInstr = resetInstrEvent;
   assign ev.stackOverflow = stackOverflowEvent;
   assign ev.stackUnderflow = stackUnderflowEvent;
   assign ev.stackResetEnable = stackEnable_q;
   assign causeSel = ev.cause;

   cause_decoder decode (
      .ev(ev.decoder)
   );

   // address match, used by both read and write paths
   function automatic logic hits(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
      hits = (a == ofs);
   endfunction

   // write strobes: a write lands at the edge where waitrequest is low
   assign wrTaken = write && !waitReq_q && byteenable[0];
   assign wrFlags = wrTaken && hits(address, FLAGS_OFS);
   assign wrStatus = wrTaken && hits(address, STATUS_OFS);
   assign wrConfig = wrTaken && hits(address, CONFIG_OFS);

   // bus handshake: one wait cycle, then one accept cycle
   always_comb begin
      waitReq_d = 1'b1;
      rdData_d = rdData_q;
      if ((read || write) && waitReq_q) begin
         waitReq_d = 1'b0;
      end
      if (read && waitReq_q) begin
         // unmapped offsets read as zero
         rdData_d = 32'h0000_0000;
         if (hits(address, FLAGS_OFS)) begin
            rdData_d[7:0] = flags_q & FLAGS_MASK;
         end else if (hits(address, STATUS_OFS)) begin
            rdData_d[4:0] = status_q; // upper bits zero
         end else if (hits(address, CONFIG_OFS)) begin
            rdData_d[CONFIG_STACK_POS] = stackEnable_q;
         end
      end
   end

   // bus registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         waitReq_q <= 1'b1;
         rdData_q <= 32'h0000_0000;
      end else if (ce) begin
         waitReq_q <= waitReq_d;
         rdData_q <= rdData_d;
      end
   end

   // flags, status and program counter action per cause
   always_comb begin
      flags_d = flags_q;
      status_d = status_q;
      stackEnable_d = stackEnable_q;
      pcLoad_d = 1'b0;
      pcValue_d = pcValue_q;
      push_d = 1'b0;
      pushAddr_d = pushAddr_q;
      retPc_d = retPc_q;
      state_d = state_q;
      // software writes first, hardware events override below
      if (wrFlags) begin
         flags_d = writedata[7:0] & FLAGS_MASK;
      end
      if (wrStatus) begin
         status_d = (status_q & ~STATUS_SW_MASK) |
                    (writedata[4:0] & STATUS_SW_MASK);
      end
      if (wrConfig) begin
         stackEnable_d = writedata[CONFIG_STACK_POS];
      end
      // stack flags are set even when no reset follows; set beats a firmware clear, but brown-out and power-on clear them
      if (stackOverflowEvent) begin
         flags_d[OVERFLOW_POS] = 1'b1;
      end
      if (stackUnderflowEvent) begin
         flags_d[UNDERFLOW_POS] = 1'b1;
      end
      case (causeSel)
         CAUSE_POWERON: begin
            flags_d = FLAGS_RESET;
            status_d = STATUS_RESET;
            pcLoad_d = 1'b1;
            pcValue_d = RESET_VECTOR;
            state_d = ST_IDLE;
         end
         CAUSE_BROWNOUT: begin
            // power-on flag kept
            flags_d[OVERFLOW_POS] = 1'b0;
            flags_d[UNDERFLOW_POS] = 1'b0;
            flags_d[PIN_POS] = 1'b1;
            flags_d[INSTR_POS] = 1'b1;
            flags_d[BROWNOUT_POS] = 1'b0;
            status_d[TIMEOUT_POS] = 1'b1;
            status_d[POWERDOWN_POS] = 1'b1;
            pcLoad_d = 1'b1;
            pcValue_d = RESET_VECTOR;
            state_d = ST_IDLE;
         end
         CAUSE_PIN: begin
            flags_d[PIN_POS] = 1'b0;
            if (inSleep) begin
               status_d[TIMEOUT_POS] = 1'b1;
               status_d[POWERDOWN_POS] = 1'b0;
            end
            pcLoad_d = 1'b1;
            pcValue_d = RESET_VECTOR;
            state_d = ST_IDLE;
         end
         CAUSE_WDT_RESET: begin
            status_d[TIMEOUT_POS] = 1'b0;
            pcLoad_d = 1'b1;
            pcValue_d = RESET_VECTOR;
            state_d = ST_IDLE;
         end
         CAUSE_INSTR: begin
            flags_d[INSTR_POS] = 1'b0;
            pcLoad_d = 1'b1;
            pcValue_d = RESET_VECTOR;
            state_d = ST_IDLE;
         end
         CAUSE_OVERFLOW, CAUSE_UNDERFLOW: begin
            // flag already set above, everything else kept
            pcLoad_d = 1'b1;
            pcValue_d = RESET_VECTOR;
            state_d = ST_IDLE;
         end
         CAUSE_WDT_WAKE: begin
            status_d[TIMEOUT_POS] = 1'b0;
            status_d[POWERDOWN_POS] = 1'b0;
            pcLoad_d = 1'b1;
            pcValue_d = currentPc + PC_STEP;
            state_d = ST_IDLE;
         end
         CAUSE_INT_WAKE: begin
            status_d[TIMEOUT_POS] = 1'b1;
            status_d[POWERDOWN_POS] = 1'b0;
            pcLoad_d = 1'b1;
            pcValue_d = currentPc + PC_STEP;
            retPc_d = currentPc + PC_STEP;
            if (globalIntEnable) begin
               state_d = ST_WAIT_INSTR;
            end else begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            // no reset: finish interrupt vectoring after one instruction
            case (state_q)
               ST_WAIT_INSTR: begin
                  if (instrDone) begin
                     push_d = 1'b1;
                     pushAddr_d = retPc_q + PC_STEP;
                     pcLoad_d = 1'b1;
                     pcValue_d = INT_VECTOR;
                     state_d = ST_IDLE;
                  end
               end
               default: begin
                  state_d = ST_IDLE;
               end
            endcase
         end
      endcase
   end

   // record registers; async reset acts as power-on
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= FLAGS_RESET;
         status_q <= STATUS_RESET;
         stackEnable_q <= CONFIG_RESET;
         pcLoad_q <= 1'b0;
         pcValue_q <= RESET_VECTOR;
         push_q <= 1'b0;
         pushAddr_q <= RESET_VECTOR;
         retPc_q <= RESET_VECTOR;
         state_q <= ST_IDLE;
      end else if (ce) begin
         flags_q <= flags_d;
         status_q <= status_d;
         stackEnable_q <= stackEnable_d;
         pcLoad_q <= pcLoad_d;
         pcValue_q <= pcValue_d;
         push_q <= push_d;
         pushAddr_q <= pushAddr_d;
         retPc_q <= retPc_d;
         state_q <= state_d;
      end
   end

   // outputs straight from flops
   assign readdata = rdData_q;
   assign waitrequest = waitReq_q;
   assign pcLoad = pcLoad_q;
   assign pcValue = pcValue_q;
   assign returnPush = push_q;
   assign returnAddr = pushAddr_q;
   assign statusBits = status_q;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence sIntWakeGie;
      ce && causeSel == CAUSE_INT_WAKE && globalIntEnable;
   endsequence

   sequence sInstrAfterWake;
      ce && state_q == ST_WAIT_INSTR && instrDone && causeSel == CAUSE_NONE;
   endsequence

   AST_PIN_RESET: assert property (
      ce && causeSel == CAUSE_PIN |=>
      !flags_q[PIN_POS] && pcLoad && pcValue == RESET_VECTOR)
      else $error("pin reset did not clear flag or vector");

   AST_PIN_SLEEP: assert property (
      ce && causeSel == CAUSE_PIN && inSleep |=>
      statusBits[TIMEOUT_POS] && !statusBits[POWERDOWN_POS])
      else $error("pin reset in sleep left wrong status");

   AST_WDT_WAKE: assert property (
      ce && causeSel == CAUSE_WDT_WAKE |=>
      statusBits[4:3] == 2'b00 && pcLoad &&
      pcValue == $past(currentPc) + PC_STEP)
      else $error("watchdog wake handled wrongly");

   AST_INT_WAKE: assert property (
      ce && causeSel == CAUSE_INT_WAKE |=>
      statusBits[4:3] == 2'b10 && pcValue == $past(currentPc) + PC_STEP)
      else $error("interrupt wake handled wrongly");

   AST_VECTOR: assert property (
      sInstrAfterWake |=>
      returnPush && pcLoad && pcValue == INT_VECTOR &&
      returnAddr == $past(retPc_q) + PC_STEP)
      else $error("interrupt vector not taken after wake");

   AST_VECTOR_ARM: assert property (
      sIntWakeGie |=> state_q == ST_WAIT_INSTR &&
      retPc_q == $past(currentPc) + PC_STEP)
      else $error("interrupt wake did not arm vectoring");

   AST_OVERFLOW: assert property (
      ce && stackOverflowEvent && !powerOnEvent && !brownoutEvent |=>
      flags_q[OVERFLOW_POS])
      else $error("overflow flag not set");

   AST_UNDERFLOW: assert property (
      ce && stackUnderflowEvent && !powerOnEvent && !brownoutEvent |=>
      flags_q[UNDERFLOW_POS])
      else $error("underflow flag not set");

   AST_UNUSED_BITS: assert property (
      ce && read && waitrequest && address == FLAGS_OFS |=>
      readdata[5:4] == 2'b00 && readdata[31:8] == 24'h000000)
      else $error("unimplemented flag bits read nonzero");

   AST_BROWNOUT: assert property (
      ce && causeSel == CAUSE_BROWNOUT && !wrFlags |=>
      !flags_q[BROWNOUT_POS] && flags_q[POWERON_POS] == $past(flags_q[1]))
      else $error("brown-out flags wrong");

   AST_WDT_RESET: assert property (
      ce && causeSel == CAUSE_WDT_RESET |=>
      !statusBits[TIMEOUT_POS] && pcValue == RESET_VECTOR)
      else $error("watchdog reset handled wrongly");

   AST_BUS_ACCEPT: assert property (
      ce && (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle after request");
endmodule

// file: reset_cause_recorder_tb_top.sv
// self-checking bench for the reset cause recorder
// assumes the package constants and the one-cycle bus answer of the note
`timescale 1ns/100ps
module reset_cause_recorder_tb_top;
   import reset_cause_pkg::*;
   logic clk_sys, reset_n, ce, read, write; // clock, reset, bus strobes
   logic inSleep, globalIntEnable, instrDone; // core side levels
   logic [3:0] address, byteenable; // bus address and lanes
   logic [31:0] writedata, readdata, rd, wd; // bus data and scratch
   logic waitrequest, pcLoad, returnPush; // design answers
   logic [8:0] evt; // one bit per event, poweron first
   logic [12:0] currentPc, pcValue, returnAddr, pc; // program counters
   logic [4:0] statusBits, expS; // status seen and expected
   logic [7:0] expF; // expected flag register
   logic expLd, enS; // expected pc load, stack reset enable
   logic [12:0] expPv; // expected pc value
   int errors, n_tests, cyc, k; // counters and event kind

   reset_cause_recorder dut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .powerOnEvent(evt[0]), .brownoutEvent(evt[1]),
      .pinResetEvent(evt[2]), .watchdogResetEvent(evt[3]),
      .resetInstrEvent(evt[4]), .stackOverflowEvent(evt[5]),
      .stackUnderflowEvent(evt[6]), .watchdogWakeEvent(evt[7]),
      .interruptWakeEvent(evt[8]), .inSleep(inSleep),
      .globalIntEnable(globalIntEnable), .instrDone(instrDone),
      .currentPc(currentPc), .pcLoad(pcLoad), .pcValue(pcValue),
      .returnPush(returnPush), .returnAddr(returnAddr),
      .statusBits(statusBits));

   // 125 MHz core clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // hang guard: a stuck run counts as a mismatch
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         errors++;
         give_verdict();
      end
   end

   // verdict and end of run
   task automatic give_verdict;
      if (errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // compare a single bit
   task automatic chkBit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // compare a field or register value
   task automatic chkVal(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // avalon read: hold until waitrequest is sampled low
   task automatic busRd(input logic [3:0] a, output logic [31:0] d);
      int n;
      @(posedge clk_sys);
      address <= a;
      read <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      d = readdata;
      read <= 1'b0;
      if (n >= 20) chkBit("waitrequest", 1'b0, waitrequest);
   endtask

   // avalon write: takes effect at the edge that sees waitrequest low
   task automatic busWr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] be);
      int n;
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      write <= 1'b0;
      if (n >= 20) chkBit("waitrequest", 1'b0, waitrequest);
   endtask

   // expected flags, status and pc action for one event kind
   function automatic void predict(int kk, logic slp, logic [12:0] p);
      expLd = 1'b1;
      expPv = RESET_VECTOR;
      case (kk)
         0: begin
            expF = FLAGS_RESET;
            expS = STATUS_RESET;
         end
         1: begin
            expF = {4'h0, 2'b11, expF[POWERON_POS], 1'b0};
            expS[4:3] = 2'b11;
         end
         2: begin
            expF[PIN_POS] = 1'b0;
            if (slp) expS[4:3] = 2'b10;
         end
         3: expS[TIMEOUT_POS] = 1'b0;
         4: expF[INSTR_POS] = 1'b0;
         5: begin
            expF[OVERFLOW_POS] = 1'b1;
            expLd = enS;
         end
         6: begin
            expF[UNDERFLOW_POS] = 1'b1;
            expLd = enS;
         end
         7: begin
            expS[4:3] = 2'b00;
            expPv = p + PC_STEP;
         end
         default: begin
            expS[4:3] = 2'b10;
            expPv = p + PC_STEP;
         end
      endcase
   endfunction

   // pulse one event, then check pc action, status and flags
   task automatic fire(input int kk, input logic slp, input logic global_int_enable);
      @(posedge clk_sys);
      evt <= 9'h001 << kk;
      inSleep <= slp;
      globalIntEnable <= global_int_enable;
      currentPc <= pc;
      predict(kk, slp, pc);
      @(posedge clk_sys);
      evt <= 9'h000;
      @(posedge clk_sys);
      chkBit("pcLoad", expLd, pcLoad);
      if (expLd) chkVal("pcValue", {19'h0, expPv}, {19'h0, pcValue});
      chkVal("status", {27'h0, expS}, {27'h0, statusBits});
      busRd(FLAGS_OFS, rd);
      chkVal("flags", {24'h0, expF}, rd);
   endtask

   // one finished instruction after a wake; vectors only with interrupts
   task automatic vecChk(input logic global_int_enable);
      @(posedge clk_sys);
      instrDone <= 1'b1;
      @(posedge clk_sys);
      instrDone <= 1'b0;
      @(posedge clk_sys);
      chkBit("returnPush", global_int_enable, returnPush);
      chkBit("pcLoad", global_int_enable, pcLoad);
      if (global_int_enable) begin
         chkVal("pcValue", {19'h0, INT_VECTOR}, {19'h0, pcValue});
         chkVal("returnAddr", {19'h0, pc + 13'h0002}, {19'h0, returnAddr});
      end
   endtask

   // firmware write of the flag register, tracked in the expectation
   task automatic wrF(input logic [31:0] d);
      busWr(FLAGS_OFS, d, 4'hF);
      expF = d[7:0] & FLAGS_MASK;
   endtask

   // main sequence
   initial begin
      {ce, read, write, inSleep, globalIntEnable, instrDone} = 6'h20;
      {address, byteenable, writedata, evt} = '0;
      {currentPc, pc, errors, n_tests, cyc} = '0;
      reset_n = 1'b0;
      void'($urandom(32'h9F6CD9AD));
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      expF = FLAGS_RESET;
      expS = STATUS_RESET;
      enS = 1'b1;
      busRd(FLAGS_OFS, rd);
      chkVal("flags", {24'h0, FLAGS_RESET}, rd);
      busRd(STATUS_OFS, rd);
      chkVal("status", {27'h0, STATUS_RESET}, rd);
      busRd(CONFIG_OFS, rd);
      chkVal("config", 32'h00000001, rd);
      busWr(4'hC, 32'hFFFFFFFF, 4'hF);
      busRd(4'hC, rd);
      chkVal("unmapped", 32'h00000000, rd);
      busWr(FLAGS_OFS, 32'h000000FF, 4'hE);
      busRd(FLAGS_OFS, rd);
      chkVal("flags", {24'h0, FLAGS_RESET}, rd);
      wrF(32'h000000FF);
      busRd(FLAGS_OFS, rd);
      chkVal("flags", 32'h000000CF, rd);
      wrF(32'h0000000F);
      busWr(STATUS_OFS, 32'h000000FF, 4'hF);
      expS = 5'h1F;
      busRd(STATUS_OFS, rd);
      chkVal("status", 32'h0000001F, rd);
      // clock enable low: a pin reset pulse is not taken
      @(posedge clk_sys);
      ce <= 1'b0;
      evt <= 9'h004;
      @(posedge clk_sys);
      evt <= 9'h000;
      @(posedge clk_sys);
      ce <= 1'b1;
      chkBit("pcLoad", 1'b0, pcLoad);
      busRd(FLAGS_OFS, rd);
      chkVal("flags", {24'h0, expF}, rd);
      pc = 13'($urandom);
      fire(2, 1'b0, 1'b0);
      fire(2, 1'b1, 1'b0);
      fire(3, 1'b0, 1'b0);
      fire(7, 1'b1, 1'b0);
      fire(4, 1'b0, 1'b0);
      fire(5, 1'b0, 1'b0);
      fire(6, 1'b0, 1'b0);
      wrF(32'h0000000F);
      busWr(CONFIG_OFS, 32'h00000000, 4'hF);
      enS = 1'b0;
      fire(5, 1'b0, 1'b0);
      fire(6, 1'b0, 1'b0);
      busWr(CONFIG_OFS, 32'h00000001, 4'hF);
      enS = 1'b1;
      fire(1, 1'b0, 1'b0);
      fire(0, 1'b0, 1'b0);
      wrF(32'h0000000F);
      pc = 13'($urandom);
      fire(8, 1'b1, 1'b0);
      vecChk(1'b0);
      pc = 13'($urandom);
      fire(8, 1'b1, 1'b1);
      vecChk(1'b1);
      // random events with random firmware state in between
      repeat (40) begin
         k = 1 + ($urandom % 8);
         wd = $urandom;
         busWr(CONFIG_OFS, wd & 32'h00000001, 4'hF);
         enS = wd[0];
         wd = $urandom;
         busWr(STATUS_OFS, wd, 4'hF);
         expS[2:0] = wd[2:0];
         wrF($urandom);
         pc = 13'($urandom);
         fire(k, 1'($urandom), 1'b0);
      end
      // mid-run reset acts as a power-on
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      chkBit("pcLoad", 1'b0, pcLoad);
      busRd(STATUS_OFS, rd);
      chkVal("status", {27'h0, STATUS_RESET}, rd);
      busRd(FLAGS_OFS, rd);
      chkVal("flags", {24'h0, FLAGS_RESET}, rd);
      give_verdict();
   end
endmodule
